// >>> common/rfc_pkg.sv
`default_nettype none
package rfc_pkg;
	// Register addresses on the plain host port
	localparam logic [5:0] RFC_A_COMMAND = 6'h01;
	localparam logic [5:0] RFC_A_MAIN_EN = 6'h02;
	localparam logic [5:0] RFC_A_MISC_EN = 6'h03;
	localparam logic [5:0] RFC_A_MAIN_FLAG = 6'h04;
	localparam logic [5:0] RFC_A_MISC_FLAG = 6'h05;
	localparam logic [5:0] RFC_A_ERROR = 6'h06;
	localparam logic [5:0] RFC_A_STATUS = 6'h07;
	localparam logic [5:0] RFC_A_DATA = 6'h09;
	localparam logic [5:0] RFC_A_LEVEL = 6'h0A;
	localparam logic [5:0] RFC_A_THRESH = 6'h0B;
	localparam logic [5:0] RFC_A_CONTROL = 6'h0C;
	localparam logic [5:0] RFC_A_MODE = 6'h11;
	localparam logic [5:0] RFC_A_CRC_HI = 6'h21;
	localparam logic [5:0] RFC_A_CRC_LO = 6'h22;
	localparam logic [5:0] RFC_A_TMODE = 6'h2A;
	localparam logic [5:0] RFC_A_TDIV_LO = 6'h2B;
	localparam logic [5:0] RFC_A_RELOAD_HI = 6'h2C;
	localparam logic [5:0] RFC_A_RELOAD_LO = 6'h2D;
	localparam logic [5:0] RFC_A_COUNT_HI = 6'h2E;
	localparam logic [5:0] RFC_A_COUNT_LO = 6'h2F;
	// Field positions
	localparam int RFC_B_FLUSH = 7;
	localparam int RFC_B_SET = 7;
	localparam int RFC_B_STOP = 7;
	localparam int RFC_B_START = 6;
	localparam int RFC_B_MSB_FIRST = 7;
	localparam int RFC_B_AUTO = 7;
	localparam int RFC_B_RESTART = 4;
	localparam int RFC_B_OVFL = 4;
	localparam int RFC_F_TIMER = 0;
	localparam int RFC_F_ERR = 1;
	localparam int RFC_F_LO = 2;
	localparam int RFC_F_HI = 3;
	localparam int RFC_F_IDLE = 4;
	localparam int RFC_F_RX = 5;
	localparam int RFC_F_TX = 6;
	localparam int RFC_F_CRC = 2;
	localparam int RFC_S_LO = 0;
	localparam int RFC_S_HI = 1;
	localparam int RFC_S_TRUN = 3;
	localparam int RFC_S_IRQ = 4;
	localparam int RFC_S_CRC_RDY = 5;
	// Commands
	localparam logic [3:0] RFC_CMD_IDLE = 4'h0;
	localparam logic [3:0] RFC_CMD_CRC = 4'h3;
	// Checksum constants
	localparam logic [15:0] RFC_POLY_MSB = 16'h1021;
	localparam logic [15:0] RFC_POLY_LSB = 16'h8408;
	localparam logic [15:0] RFC_PRESET_0 = 16'h0000;
	localparam logic [15:0] RFC_PRESET_1 = 16'h6363;
	localparam logic [15:0] RFC_PRESET_2 = 16'hA671;
	localparam logic [15:0] RFC_PRESET_3 = 16'hFFFF;
	typedef enum logic {RFC_T_STOP = 1'b0, RFC_T_RUN = 1'b1} rfc_tstate_t;
	typedef struct packed {
		logic [5:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rfc_bus_t;
endpackage
`default_nettype wire

// >>> hdl/rfc_core.sv
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module rfc_core
	import rfc_pkg::*;
#(
	parameter int DEPTH = 64
)(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire rfc_bus_t i_bus,
	output logic [7:0] o_rdata,
	input wire logic i_sm_push,
	input wire logic [7:0] i_sm_data,
	input wire logic i_sm_pop,
	output logic [7:0] o_sm_data,
	input wire logic i_tx_end,
	input wire logic i_rx_end,
	input wire logic i_cmd_done,
	input wire logic [7:0] i_err_set,
	output logic [3:0] o_command,
	output logic o_timer_active,
	output logic o_irq
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [6:0] DEPTH7 = 7'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][7:0] mem;
		logic [AW-1:0] wp;
		logic [AW-1:0] rp;
		logic [6:0] count;
		logic ovfl;
		logic [7:0] err;
		logic [5:0] thr;
		logic lo_prev;
		logic hi_prev;
		logic [3:0] cmd;
		logic [6:0] main_en;
		logic [6:0] main_flag;
		logic misc_en;
		logic misc_flag;
		logic irq;
		logic msb_first;
		logic [1:0] preset_sel;
		logic crc_busy;
		logic crc_ready;
		logic [15:0] crc;
		logic t_auto;
		logic t_restart;
		logic [11:0] t_div;
		logic [15:0] t_reload;
		logic [15:0] t_count;
		logic [12:0] t_psc;
		rfc_tstate_t t_state;
		logic [7:0] rdata;
		logic [7:0] sm_q;
	} rfc_state_t;

	rfc_state_t s;
	rfc_state_t next_s;

	function automatic logic [15:0] rfc_crc_byte(input logic [15:0] c, input logic [7:0] d, input logic msb);
		logic [15:0] r;
		logic fb;
		r = c;
		for (int i = 0; i < 8; i++)
		begin
			if (msb)
			begin
				fb = r[15] ^ d[7 - i];
				r = {r[14:0], 1'b0} ^ (fb ? RFC_POLY_MSB : 16'h0000);
			end
			else
			begin
				fb = r[0] ^ d[i];
				r = {1'b0, r[15:1]} ^ (fb ? RFC_POLY_LSB : 16'h0000);
			end
		end
		return r;
	endfunction

	logic wr_hit;
	logic rd_hit;
	logic lo_now;
	logic hi_now;
	logic [7:0] head;
	logic [7:0] err_view;
	logic [15:0] preset_val;
	logic crc_pop;
	logic push_req;
	logic pop_req;
	logic do_push;
	logic do_pop;
	logic [7:0] push_byte;
	logic t_tick;
	logic t_start;
	logic t_stop;

	always_comb
	begin
		wr_hit = i_bus.wr;
		rd_hit = i_bus.rd;
		head = (s.count == 7'h00) ? 8'h00 : s.mem[s.rp];
		lo_now = s.count <= {1'b0, s.thr};
		hi_now = (DEPTH7 - s.count) <= {1'b0, s.thr};
		err_view = s.err;
		err_view[RFC_B_OVFL] = s.ovfl;
		case (s.preset_sel)
			2'b00: preset_val = RFC_PRESET_0;
			2'b01: preset_val = RFC_PRESET_1;
			2'b10: preset_val = RFC_PRESET_2;
			default: preset_val = RFC_PRESET_3;
		endcase
		// Checksum engine has first claim on the queue head; sharing is the host's concern
		crc_pop = s.crc_busy && (s.count != 7'h00);
		push_req = i_sm_push || (wr_hit && i_bus.addr == RFC_A_DATA);
		push_byte = i_sm_push ? i_sm_data : i_bus.wdata;
		pop_req = crc_pop || i_sm_pop || (rd_hit && i_bus.addr == RFC_A_DATA);
		do_push = push_req && (s.count != DEPTH7);
		do_pop = pop_req && (s.count != 7'h00);
		t_tick = (s.t_state == RFC_T_RUN) && (s.t_psc == 13'h0000);
		t_start = (wr_hit && i_bus.addr == RFC_A_CONTROL && i_bus.wdata[RFC_B_START])
			|| (i_tx_end && s.t_auto);
		t_stop = wr_hit && i_bus.addr == RFC_A_CONTROL && i_bus.wdata[RFC_B_STOP];
	end

	always_comb
	begin
		next_s = s;
		// Queue data path
		if (do_push)
		begin
			next_s.mem[s.wp] = push_byte;
			next_s.wp = s.wp + 1'b1;
		end
		if (do_pop)
			next_s.rp = s.rp + 1'b1;
		next_s.count = s.count + {6'h00, do_push} - {6'h00, do_pop};
		if (i_sm_pop)
			next_s.sm_q = head;
		// Host register writes
		if (wr_hit)
		begin
			case (i_bus.addr)
				RFC_A_COMMAND:
				begin
					next_s.cmd = i_bus.wdata[3:0];
					if (i_bus.wdata[3:0] != RFC_CMD_IDLE)
						next_s.err = 8'h00;
					if (i_bus.wdata[3:0] == RFC_CMD_CRC)
					begin
						next_s.crc_busy = 1'b1;
						next_s.crc_ready = 1'b0;
						next_s.crc = preset_val;
					end
				end
				RFC_A_MAIN_EN: next_s.main_en = i_bus.wdata[6:0];
				RFC_A_MISC_EN: next_s.misc_en = i_bus.wdata[RFC_F_CRC];
				RFC_A_MAIN_FLAG:
				begin
					if (i_bus.wdata[RFC_B_SET])
						next_s.main_flag = s.main_flag | i_bus.wdata[6:0];
					else
						next_s.main_flag = s.main_flag & ~i_bus.wdata[6:0];
				end
				RFC_A_MISC_FLAG:
				begin
					if (i_bus.wdata[RFC_F_CRC])
						next_s.misc_flag = i_bus.wdata[RFC_B_SET];
				end
				RFC_A_LEVEL:
				begin
					if (i_bus.wdata[RFC_B_FLUSH])
					begin
						next_s.wp = '0;
						next_s.rp = '0;
						next_s.count = 7'h00;
						next_s.ovfl = 1'b0;
					end
				end
				RFC_A_THRESH: next_s.thr = i_bus.wdata[5:0];
				RFC_A_MODE:
				begin
					next_s.msb_first = i_bus.wdata[RFC_B_MSB_FIRST];
					next_s.preset_sel = i_bus.wdata[1:0];
				end
				RFC_A_TMODE:
				begin
					next_s.t_auto = i_bus.wdata[RFC_B_AUTO];
					next_s.t_restart = i_bus.wdata[RFC_B_RESTART];
					next_s.t_div[11:8] = i_bus.wdata[3:0];
				end
				RFC_A_TDIV_LO: next_s.t_div[7:0] = i_bus.wdata;
				RFC_A_RELOAD_HI: next_s.t_reload[15:8] = i_bus.wdata;
				RFC_A_RELOAD_LO: next_s.t_reload[7:0] = i_bus.wdata;
				default: ;
			endcase
		end
		// Overflow set after the flush so a simultaneous event is kept
		if (push_req && s.count == DEPTH7)
			next_s.ovfl = 1'b1;
		next_s.err = next_s.err | (i_err_set & ~8'h10);
		// Checksum engine: one byte per cycle straight off the queue head
		if (crc_pop)
			next_s.crc = rfc_crc_byte(s.crc, head, s.msb_first);
		if (s.crc_busy && s.count == 7'h00)
		begin
			next_s.crc_busy = 1'b0;
			next_s.crc_ready = 1'b1;
			next_s.misc_flag = 1'b1;
			next_s.cmd = RFC_CMD_IDLE;
			next_s.main_flag[RFC_F_IDLE] = 1'b1;
		end
		if (i_cmd_done && s.cmd != RFC_CMD_IDLE)
		begin
			next_s.cmd = RFC_CMD_IDLE;
			next_s.main_flag[RFC_F_IDLE] = 1'b1;
		end
		// Timer: prescaler reloads with 2P so each tick spans 2P+1 cycles
		if (s.t_state == RFC_T_RUN)
		begin
			if (t_tick)
			begin
				next_s.t_psc = {s.t_div, 1'b0};
				if (s.t_count == 16'h0001)
				begin
					next_s.t_count = 16'h0000;
					next_s.main_flag[RFC_F_TIMER] = 1'b1;
					if (!s.t_restart)
						next_s.t_state = RFC_T_STOP;
				end
				else if (s.t_count == 16'h0000)
					next_s.t_count = s.t_reload;
				else
					next_s.t_count = s.t_count - 16'h0001;
			end
			else
				next_s.t_psc = s.t_psc - 13'h0001;
		end
		if (t_stop)
			next_s.t_state = RFC_T_STOP;
		else if (t_start)
		begin
			next_s.t_state = RFC_T_RUN;
			next_s.t_psc = {s.t_div, 1'b0};
			next_s.t_count = s.t_reload;
		end
		// Event flags: hardware set wins over a host clear in the same cycle
		if (i_tx_end)
			next_s.main_flag[RFC_F_TX] = 1'b1;
		if (i_rx_end)
			next_s.main_flag[RFC_F_RX] = 1'b1;
		if (err_view != 8'h00)
			next_s.main_flag[RFC_F_ERR] = 1'b1;
		next_s.lo_prev = lo_now;
		next_s.hi_prev = hi_now;
		if (lo_now && !s.lo_prev)
			next_s.main_flag[RFC_F_LO] = 1'b1;
		if (hi_now && !s.hi_prev)
			next_s.main_flag[RFC_F_HI] = 1'b1;
		next_s.irq = (|(next_s.main_flag & next_s.main_en)) || (next_s.misc_flag && next_s.misc_en);
		// Read data stands in the cycle after the strobe only
		next_s.rdata = 8'h00;
		if (rd_hit)
		begin
			case (i_bus.addr)
				RFC_A_COMMAND: next_s.rdata = {4'h0, s.cmd};
				RFC_A_MAIN_EN: next_s.rdata = {1'b0, s.main_en};
				RFC_A_MISC_EN: next_s.rdata = {5'h00, s.misc_en, 2'b00};
				RFC_A_MAIN_FLAG: next_s.rdata = {1'b0, s.main_flag};
				RFC_A_MISC_FLAG: next_s.rdata = {5'h00, s.misc_flag, 2'b00};
				RFC_A_ERROR: next_s.rdata = err_view;
				RFC_A_STATUS: next_s.rdata = {2'b00, s.crc_ready, s.irq, (s.t_state == RFC_T_RUN), 1'b0, hi_now, lo_now};
				RFC_A_DATA: next_s.rdata = head;
				RFC_A_LEVEL: next_s.rdata = {1'b0, s.count};
				RFC_A_THRESH: next_s.rdata = {2'b00, s.thr};
				RFC_A_MODE: next_s.rdata = {s.msb_first, 5'h00, s.preset_sel};
				RFC_A_CRC_HI: next_s.rdata = s.crc[15:8];
				RFC_A_CRC_LO: next_s.rdata = s.crc[7:0];
				RFC_A_TMODE: next_s.rdata = {s.t_auto, 2'b00, s.t_restart, s.t_div[11:8]};
				RFC_A_TDIV_LO: next_s.rdata = s.t_div[7:0];
				RFC_A_RELOAD_HI: next_s.rdata = s.t_reload[15:8];
				RFC_A_RELOAD_LO: next_s.rdata = s.t_reload[7:0];
				RFC_A_COUNT_HI: next_s.rdata = s.t_count[15:8];
				RFC_A_COUNT_LO: next_s.rdata = s.t_count[7:0];
				default: next_s.rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
			s <= '0;
		else
			s <= next_s;
	end

	assign o_rdata = s.rdata;
	assign o_sm_data = s.sm_q;
	assign o_command = s.cmd;
	assign o_timer_active = (s.t_state == RFC_T_RUN);
	assign o_irq = s.irq;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	logic host_push_only;
	logic flush_wr;
	assign host_push_only = wr_hit && i_bus.addr == RFC_A_DATA && !i_sm_push && !pop_req;
	assign flush_wr = wr_hit && i_bus.addr == RFC_A_LEVEL && i_bus.wdata[RFC_B_FLUSH];

	sequence s_crc_last;
		s.crc_busy && s.count == 7'h00;
	endsequence
	sequence s_crc_finished;
		s.crc_ready && s.misc_flag && !s.crc_busy;
	endsequence
	sequence s_timer_last;
		t_tick && s.t_count == 16'h0001 && !t_start;
	endsequence

	property p_push;
		host_push_only && s.count < DEPTH7 |=> s.count == $past(s.count) + 7'h01;
	endproperty
	a_push: assert property (p_push) else $error("Host push did not raise count");
	property p_full_drop;
		host_push_only && s.count == DEPTH7 |=> s.count == DEPTH7 && s.ovfl && s.wp == $past(s.wp);
	endproperty
	a_full_drop: assert property (p_full_drop) else $error("Full push not dropped");
	property p_flush;
		flush_wr && !i_sm_push |=> s.count == 7'h00 && !s.ovfl && s.rp == s.wp;
	endproperty
	a_flush: assert property (p_flush) else $error("Flush did not empty queue");
	property p_ovfl_hold;
		s.ovfl && !flush_wr |=> s.ovfl;
	endproperty
	a_ovfl_hold: assert property (p_ovfl_hold) else $error("Overflow cleared without flush");
	property p_level;
		s.count <= DEPTH7 && s.count[AW-1:0] == AW'(s.wp - s.rp);
	endproperty
	a_level: assert property (p_level) else $error("Count disagrees with pointers");
	property p_alerts;
		rd_hit && i_bus.addr == RFC_A_STATUS |=> o_rdata[RFC_S_LO] == ($past(s.count) <= 7'($past(s.thr)))
			&& o_rdata[RFC_S_HI] == (($past(s.count) + 7'($past(s.thr))) >= DEPTH7);
	endproperty
	a_alerts: assert property (p_alerts) else $error("Alert status wrong");
	property p_crc_done;
		s_crc_last |=> s_crc_finished;
	endproperty
	a_crc_done: assert property (p_crc_done) else $error("Checksum done not reported");
	property p_timer_flag;
		s_timer_last |=> s.main_flag[RFC_F_TIMER] && s.t_count == 16'h0000;
	endproperty
	a_timer_flag: assert property (p_timer_flag) else $error("Timer expiry flag missing");
	property p_tick_gap;
		t_tick && !t_start && !t_stop && s.t_div == 12'h002 |=> !t_tick [*4] ##1
			(t_tick || !o_timer_active || $past(t_start) || $past(t_start, 2) || $past(t_start, 3) || $past(t_start, 4));
	endproperty
	a_tick_gap: assert property (p_tick_gap) else $error("Prescaler period wrong");
	property p_irq;
		(|(s.main_flag & s.main_en)) |-> o_irq;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt pin not driven");
	property p_lo_edge;
		lo_now && !s.lo_prev |=> s.main_flag[RFC_F_LO];
	endproperty
	a_lo_edge: assert property (p_lo_edge) else $error("Almost-empty flag missing");
endmodule
`default_nettype wire

// >>> tb/rfc_host.sv
`timescale 1ns/1ns
`default_nettype none
module rfc_host
	import rfc_pkg::*;
(
	input wire logic i_clk,
	input wire logic [7:0] i_rdata,
	output var rfc_bus_t o_bus
);
	initial o_bus = '0;
	// One strobe per transfer, dropped at the edge that takes it
	task automatic write(input logic [5:0] a, input logic [7:0] v);
		@(posedge i_clk);
		o_bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge i_clk);
		o_bus <= '0;
	endtask
	// Read data only stands in the cycle after the strobe
	task automatic read(input logic [5:0] a, output logic [7:0] v);
		@(posedge i_clk);
		o_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clk);
		o_bus <= '0;
		#1;
		v = i_rdata;
	endtask
endmodule
`default_nettype wire

// >>> tb/rfc_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module rfc_core_tb
	import rfc_pkg::*;
();
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] b0;
		logic [7:0] b1;
		logic [15:0] crc;
	} rfc_row_t;
	logic clk, rstn, sm_push, sm_pop, tx_end, rx_end, cmd_done, tact, irq;
	logic [7:0] sm_data, err_set, rdata, d, sm_out;
	logic [3:0] command;
	rfc_bus_t bus;
	int num_errors, total_checks, i;
	time t_prev, t_last;
	// Expected checksums worked out by hand from the generator and preset
	rfc_row_t rows [4] = '{'{8'h00, 8'h12, 8'h34, 16'hD186}, '{8'h81, 8'hA5, 8'h00, 16'hE037},
		'{8'h02, 8'hFF, 8'h3C, 16'h2D0F}, '{8'h83, 8'h01, 8'h80, 16'hBFB6}};

	rfc_core #(.DEPTH(64)) u_rfc_core(.i_clk(clk), .i_rstn(rstn), .i_bus(bus), .o_rdata(rdata),
		.i_sm_push(sm_push), .i_sm_data(sm_data), .i_sm_pop(sm_pop), .o_sm_data(sm_out),
		.i_tx_end(tx_end), .i_rx_end(rx_end), .i_cmd_done(cmd_done), .i_err_set(err_set),
		.o_command(command), .o_timer_active(tact), .o_irq(irq));
	rfc_host u_rfc_host(.i_clk(clk), .i_rdata(rdata), .o_bus(bus));

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] v);
		u_rfc_host.write(a, v);
	endtask
	task automatic rd(input logic [5:0] a);
		u_rfc_host.read(a, d);
	endtask
	task automatic wrap_up();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial
	begin
		#1_000_000;
		num_errors++;
		wrap_up();
	end
	always @(posedge irq)
	begin
		t_prev = t_last;
		t_last = $time;
	end

	initial
	begin
		{rstn, sm_push, sm_pop, tx_end, rx_end, cmd_done, sm_data, err_set} = '0;
		num_errors = 0;
		total_checks = 0;
		t_last = 0;
		t_prev = 0;
		repeat (2) @(posedge clk);
		rstn <= 1'b1;
		rd(RFC_A_LEVEL);
		chk(d, 8'h00);
		rd(RFC_A_STATUS);
		chk(d[1:0], 2'b01);
		rd(6'h3F);
		chk(d, 8'h00);
		chk(irq, 1'b0);
		for (i = 0; i < 4; i++)
		begin
			wr(RFC_A_LEVEL, 8'h80);
			wr(RFC_A_MISC_FLAG, 8'h04);
			wr(RFC_A_MAIN_FLAG, 8'h7F);
			wr(RFC_A_MODE, rows[i].mode);
			wr(RFC_A_DATA, rows[i].b0);
			wr(RFC_A_DATA, rows[i].b1);
			wr(RFC_A_COMMAND, {4'h0, RFC_CMD_CRC});
			d = 8'h00;
			// Only status is polled while the command owns the queue
			for (int w = 0; w < 20 && !(d[RFC_S_CRC_RDY] === 1'b1 && command === RFC_CMD_IDLE); w++)
				rd(RFC_A_STATUS);
			chk(d[RFC_S_CRC_RDY], 1'b1);
			rd(RFC_A_CRC_HI);
			chk(d, rows[i].crc[15:8]);
			rd(RFC_A_CRC_LO);
			chk(d, rows[i].crc[7:0]);
			rd(RFC_A_MISC_FLAG);
			chk(d[RFC_F_CRC], 1'b1);
			rd(RFC_A_MAIN_FLAG);
			chk(d[RFC_F_IDLE], 1'b1);
		end
		wr(RFC_A_THRESH, 8'h04);
		wr(RFC_A_LEVEL, 8'h80);
		wr(RFC_A_MAIN_FLAG, 8'h7F);
		wr(RFC_A_MAIN_EN, 8'h08);
		for (i = 0; i < 65; i++)
			wr(RFC_A_DATA, 8'(i) + 8'h40);
		chk(irq, 1'b1);
		rd(RFC_A_STATUS);
		chk(d[RFC_S_IRQ], 1'b1);
		rd(RFC_A_LEVEL);
		chk(d, 8'h40);
		rd(RFC_A_ERROR);
		chk(d[RFC_B_OVFL], 1'b1);
		for (i = 0; i < 64; i++)
		begin
			rd(RFC_A_DATA);
			chk(d, 8'(i) + 8'h40);
			rd(RFC_A_STATUS);
			chk(d[1:0], {i <= 3, i >= 59});
		end
		rd(RFC_A_DATA);
		chk(d, 8'h00);
		rd(RFC_A_ERROR);
		chk(d[RFC_B_OVFL], 1'b1);
		wr(RFC_A_LEVEL, 8'h80);
		rd(RFC_A_ERROR);
		chk(d[RFC_B_OVFL], 1'b0);
		rd(RFC_A_LEVEL);
		chk(d, 8'h00);
		// Host to state machine, then state machine to host, through the one queue
		wr(RFC_A_DATA, 8'h5A);
		@(posedge clk);
		sm_pop <= 1'b1;
		@(posedge clk);
		{sm_pop, sm_push, sm_data} <= {1'b0, 1'b1, 8'hC3};
		@(posedge clk);
		sm_push <= 1'b0;
		rd(RFC_A_DATA);
		chk(d, 8'hC3);
		chk(sm_out, 8'h5A);
		wr(RFC_A_MAIN_EN, 8'h00);
		rd(RFC_A_LEVEL);
		chk(irq, 1'b0);
		wr(RFC_A_TMODE, 8'h90);
		wr(RFC_A_TDIV_LO, 8'h02);
		wr(RFC_A_RELOAD_HI, 8'h00);
		wr(RFC_A_RELOAD_LO, 8'h03);
		wr(RFC_A_MAIN_FLAG, 8'h7F);
		// A running command is needed for completion to raise the idle flag
		wr(RFC_A_COMMAND, 8'h01);
		@(posedge clk);
		{tx_end, rx_end, cmd_done, err_set} <= {3'b111, 8'h01};
		@(posedge clk);
		{tx_end, rx_end, cmd_done, err_set} <= '0;
		rd(RFC_A_MAIN_FLAG);
		chk(d[6:4], 3'b111);
		chk(d[RFC_F_ERR], 1'b1);
		chk(command, RFC_CMD_IDLE);
		chk(tact, 1'b1);
		wr(RFC_A_MAIN_EN, 8'h01);
		// Flag is cleared after each rise so the next expiry makes a fresh edge
		for (i = 0; i < 3; i++)
		begin
			for (int w = 0; w < 100 && irq !== 1'b1; w++)
				@(posedge clk);
			wr(RFC_A_MAIN_FLAG, 8'h01);
			repeat (2) @(posedge clk);
		end
		chk(16'(t_last - t_prev), 16'd1000);
		rd(RFC_A_COUNT_HI);
		chk(d, 8'h00);
		wr(RFC_A_CONTROL, 8'h80);
		#1;
		chk(tact, 1'b0);
		wr(RFC_A_CONTROL, 8'h40);
		#1;
		chk(tact, 1'b1);
		wr(RFC_A_CONTROL, 8'hC0);
		#1;
		chk(tact, 1'b0);
		// One-shot mode: stops by itself once the count reaches zero
		wr(RFC_A_TMODE, 8'h00);
		wr(RFC_A_CONTROL, 8'h40);
		#1;
		chk(tact, 1'b1);
		repeat (20) @(posedge clk);
		#1;
		chk(tact, 1'b0);
		rd(RFC_A_COUNT_LO);
		chk(d, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
